// *** sim/pma_board.sv ***
// Board-side model that drives the device clock pin of the macrocell array.
`timescale 1ns/1ps
module pma_board
(
	input wire logic clk_sys,
	input wire logic pu_busy,
	input wire logic tick,
	output logic dev_clk
);
	// The pin rises one cycle after the request so that array setup is met.
	initial
	begin
		dev_clk = 1'b0;
		forever
		begin
			@(posedge clk_sys);
			if (tick && !pu_busy)
			begin
				@(negedge clk_sys);
				dev_clk = 1'b1;
				repeat (2) @(negedge clk_sys);
				dev_clk = 1'b0;
			end
		end
	end
endmodule

// *** sim/test_programmable_macrocell_array.sv ***
// Self-checking bench for the macrocell array with a board clock model.
`timescale 1ns/1ps
module test_programmable_macrocell_array;
	import pma_pkg::*;
	logic clk_sys, rst, tick, dev_clk, cfg_we, rb_re, pl_we, sec_set, sig_we, sig_re;
	logic [11:0] pv, drv, in_pin;
	logic [9:0] io_in, io_drv, io_out, io_oe, pl_mask, pl_data;
	logic [7:0] cfg_row, rb_row, sig_wdata, sig_data;
	logic [43:0] cfg_wdata, rb_data;
	logic [2:0] sig_idx;
	logic rb_valid, rb_refused, pl_refused, sec_locked, sig_valid, pu_busy;
	logic [3:0] tab [4] = '{4'h0, 4'h5, 4'hA, 4'hF};
	int fail_count = 0;
	int tests_run = 0;
	assign in_pin = {pv[11:1], dev_clk};
	pma_board pma_board_i (.clk_sys(clk_sys), .pu_busy(pu_busy), .tick(tick), .dev_clk(dev_clk));
	pma_top pma_top_i (.clk_sys(clk_sys), .rst(rst), .in_pin(in_pin), .in_drv(drv),
		.io_in(io_in), .io_drv(io_drv), .io_out(io_out), .io_oe(io_oe), .cfg_we(cfg_we),
		.cfg_row(cfg_row), .cfg_wdata(cfg_wdata), .rb_re(rb_re), .rb_row(rb_row),
		.rb_data(rb_data), .rb_valid(rb_valid), .rb_refused(rb_refused), .pl_we(pl_we),
		.pl_mask(pl_mask), .pl_data(pl_data), .pl_refused(pl_refused), .sec_set(sec_set),
		.sec_locked(sec_locked), .sig_we(sig_we), .sig_idx(sig_idx), .sig_wdata(sig_wdata),
		.sig_re(sig_re), .sig_data(sig_data), .sig_valid(sig_valid), .pu_busy(pu_busy));
	initial
	begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end
	task automatic chk(input logic [43:0] seen, input logic [43:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("ERROR %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic results;
		$display("checks %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic wr(input logic [7:0] row, input logic [43:0] d);
		cfg_we = 1'b1;
		cfg_row = row;
		cfg_wdata = d;
		@(negedge clk_sys);
	endtask
	task automatic rd(input logic [7:0] row, input logic v, input logic r, input logic [43:0] d);
		rb_re = 1'b1;
		rb_row = row;
		@(negedge clk_sys);
		rb_re = 1'b0;
		chk(rb_valid, v);
		chk(rb_refused, r);
		chk(rb_data, d);
		@(negedge clk_sys);
	endtask
	task automatic pl(input logic [9:0] d);
		pl_we = 1'b1;
		pl_mask = 10'h002;
		pl_data = d;
		@(negedge clk_sys);
		pl_we = 1'b0;
	endtask
	task automatic dclk;
		tick = 1'b1;
		@(negedge clk_sys);
		tick = 1'b0;
		repeat (5) @(negedge clk_sys);
	endtask
	initial
	begin
		#200000;
		fail_count++;
		results();
	end
	initial
	begin
		{rst, tick, cfg_we, rb_re, pl_we, sec_set, sig_we, sig_re} = 8'hFF << 7;
		{pv, io_in, io_drv, pl_mask, pl_data, cfg_row, rb_row, sig_wdata, sig_idx} = '0;
		cfg_wdata = '0;
		drv = 12'hFFF;
		repeat (20) @(negedge clk_sys);
		chk({io_oe, io_out, pu_busy, sec_locked}, 22'h2);
		rst = 1'b0;
		repeat (9) @(negedge clk_sys);
		chk(pu_busy, 1'b1);
		@(negedge clk_sys);
		chk(pu_busy, 1'b0);
		// Macrocell 0 is combinatorial; macrocell 1 is registered and active low.
		wr(8'h00, 44'h4);
		wr(8'h10, 44'h4);
		wr(8'hA0, 44'h10);
		wr(8'hA1, 44'h10);
		wr(8'hAD, 44'h3);
		wr(8'hAA, 44'h40);
		wr(8'hAB, 44'h100);
		cfg_we = 1'b0;
		for (int i = 0; i < 4; i++)
		begin
			pv[2:1] = tab[i][3:2];
			@(negedge clk_sys);
			chk(io_oe[0], tab[i][1]);
			chk(io_out[0], tab[i][0]);
			chk(io_out[1], 1'b1);
		end
		drv[1] = 1'b0;
		pv[1] = 1'b0;
		repeat (2) @(negedge clk_sys);
		chk(io_out[0], 1'b1);
		drv[1] = 1'b1;
		pv[1] = 1'b1;
		dclk();
		chk(io_out[1], 1'b0);
		pl(10'h000);
		chk(io_out[1], 1'b1);
		pl(10'h002);
		chk(io_out[1], 1'b0);
		pv[3] = 1'b1;
		#1;
		chk(io_out[1], 1'b1);
		@(negedge clk_sys);
		chk(io_out[1], 1'b1);
		pv[3] = 1'b0;
		@(negedge clk_sys);
		chk(io_out[1], 1'b1);
		pv[4] = 1'b1;
		pv[1] = 1'b0;
		dclk();
		chk(io_out[1], 1'b0);
		pv[4] = 1'b0;
		pv[1] = 1'b1;
		// Macrocell 2 takes the registered feedback of macrocell 1 as its only literal.
		wr(8'h20, 44'h4000000);
		cfg_we = 1'b0;
		chk(io_out[2], 1'b1);
		rd(8'h00, 1'b1, 1'b0, 44'h4);
		sig_we = 1'b1;
		sig_idx = 3'h3;
		sig_wdata = 8'hA5;
		@(negedge clk_sys);
		sig_we = 1'b0;
		sec_set = 1'b1;
		@(negedge clk_sys);
		sec_set = 1'b0;
		chk(sec_locked, 1'b1);
		rd(8'h00, 1'b0, 1'b1, 44'h0);
		pl(10'h000);
		chk(pl_refused, 1'b1);
		chk(io_out[1], 1'b0);
		sig_re = 1'b1;
		@(negedge clk_sys);
		sig_re = 1'b0;
		chk({sig_valid, sig_data}, 9'h1A5);
		// A second power-up in mid-run clears registers and erases the part.
		rst = 1'b1;
		@(negedge clk_sys);
		chk({sec_locked, pu_busy, io_oe, io_out}, 22'h100000);
		rst = 1'b0;
		repeat (9) @(negedge clk_sys);
		chk(pu_busy, 1'b1);
		@(negedge clk_sys);
		chk(pu_busy, 1'b0);
		rd(8'h00, 1'b1, 1'b0, 44'h0);
		results();
	end
endmodule

// *** verilog/pma_pkg.sv ***
// Constants shared by the programmable macrocell array and its product-term cell.
package pma_pkg;
	localparam int IN_N = 12;
	localparam int MC_N = 10;
	localparam int LINES_N = IN_N + MC_N;
	localparam int FUSE_W = 2 * LINES_N;
	localparam int TERM_MAX = 16;
	localparam int TERM_CNT [MC_N] = '{8, 10, 12, 14, 16, 16, 14, 12, 10, 8};
	localparam int ROW_OE_BASE = MC_N * TERM_MAX;
	localparam int ROW_AR = ROW_OE_BASE + MC_N;
	localparam int ROW_SP = ROW_AR + 1;
	localparam int ROW_MODE_BASE = ROW_SP + 1;
	localparam int ROW_COUNT = ROW_MODE_BASE + MC_N;
	localparam int ROW_W = 8;
	localparam logic [ROW_W-1:0] ROW_LIMIT = ROW_W'(ROW_COUNT);
	localparam int MODE_REG_BIT = 0;
	localparam int MODE_POL_BIT = 1;
	localparam int CLK_PIN_BIT = 0;
	localparam int SIG_BYTES = 8;
	localparam int SIG_IDX_W = 3;
	localparam int PU_TIME_NS = 1000;
	localparam int CLK_PERIOD_NS = 100;
	localparam int PU_CYCLES = (PU_TIME_NS / CLK_PERIOD_NS < 1) ? 1 : PU_TIME_NS / CLK_PERIOD_NS;
	localparam int PU_CNT_W = $clog2(PU_CYCLES + 1);
	typedef enum logic {PU_HOLD, PU_RUN} pma_pu_t;
endpackage

// *** verilog/pma_term.sv ***
// One product term: the AND of every array literal whose fuse connects it.
`timescale 1ns/1ps
module pma_term
#(
	parameter int N_IN = 22
)
(
	input wire logic [N_IN-1:0] lines,
	input wire logic [2*N_IN-1:0] fuse,
	output logic hit
);
	logic [N_IN-1:0] ok;

	for (genvar k = 0; k < N_IN; k++)
	begin : g_lit
		// Even fuse connects the true literal, odd fuse the complement.
		assign ok[k] = ~((fuse[2*k] & ~lines[k]) | (fuse[2*k+1] & lines[k]));
	end

	// A term with no fuse connected is switched off rather than stuck true.
	assign hit = (|fuse) & (&ok);
endmodule

// *** verilog/pma_top.sv ***
// Sum-of-products macrocell array with preload, security lock, signature and keepers.
//
// Notes on behaviour
// - Twelve dedicated inputs plus ten macrocell feedbacks all feed the product terms.
// - Each macrocell picks registered or combinatorial, and active high or low.
// - A combinatorial macrocell output follows its product-term sum with no clock.
// - A product term per macrocell enables or floats its output driver.
// - An array-derived reset term clears all macrocell registers regardless of clock.
// - An array-derived preset term sets all registers at a device clock edge.
// - After power-up every register is cleared; pin level then follows polarity.
// - Preload forces each register individually high or low for testing.
// - Once secured, fuse readback and preload are refused at once.
// - Sixty-four signature bits stay readable whether or not the part is secured.
// - Undriven input and I/O pins keep their last driven level.
// - The ten macrocells receive between eight and sixteen product terms each.
`timescale 1ns/1ps
module pma_top
(
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic [pma_pkg::IN_N-1:0] in_pin,
	input wire logic [pma_pkg::IN_N-1:0] in_drv,
	input wire logic [pma_pkg::MC_N-1:0] io_in,
	input wire logic [pma_pkg::MC_N-1:0] io_drv,
	output logic [pma_pkg::MC_N-1:0] io_out,
	output logic [pma_pkg::MC_N-1:0] io_oe,
	input wire logic cfg_we,
	input wire logic [pma_pkg::ROW_W-1:0] cfg_row,
	input wire logic [pma_pkg::FUSE_W-1:0] cfg_wdata,
	input wire logic rb_re,
	input wire logic [pma_pkg::ROW_W-1:0] rb_row,
	output logic [pma_pkg::FUSE_W-1:0] rb_data,
	output logic rb_valid,
	output logic rb_refused,
	input wire logic pl_we,
	input wire logic [pma_pkg::MC_N-1:0] pl_mask,
	input wire logic [pma_pkg::MC_N-1:0] pl_data,
	output logic pl_refused,
	input wire logic sec_set,
	output logic sec_locked,
	input wire logic sig_we,
	input wire logic [pma_pkg::SIG_IDX_W-1:0] sig_idx,
	input wire logic [7:0] sig_wdata,
	input wire logic sig_re,
	output logic [7:0] sig_data,
	output logic sig_valid,
	output logic pu_busy
);
	import pma_pkg::*;

	logic [FUSE_W-1:0] fuse_ff [ROW_COUNT];
	logic [7:0] sig_ff [SIG_BYTES];
	logic [IN_N-1:0] in_keep_ff;
	logic [MC_N-1:0] io_keep_ff;
	logic [MC_N-1:0] mc_q_ff;
	logic clk_pin_q_ff;
	logic sec_ff;
	pma_pu_t pu_state_ff;
	logic [PU_CNT_W-1:0] pu_cnt_ff;
	logic [FUSE_W-1:0] rb_data_ff;
	logic rb_valid_ff;
	logic rb_refused_ff;
	logic pl_refused_ff;
	logic [7:0] sig_data_ff;
	logic sig_valid_ff;

	logic [IN_N-1:0] in_level;
	logic [MC_N-1:0] io_level;
	logic [MC_N-1:0] fb;
	logic [LINES_N-1:0] lines;
	logic [MC_N-1:0][TERM_MAX-1:0] term_hit;
	logic [MC_N-1:0] sum;
	logic [MC_N-1:0] oe_hit;
	logic [MC_N-1:0] mode_reg;
	logic [MC_N-1:0] mode_pol;
	logic [MC_N-1:0] q_eff;
	logic ar_hit;
	logic sp_hit;
	logic dev_edge;
	logic locked_now;
	logic pl_go;

	// Keepers: a pin nobody drives reads as the level it last had.
	assign in_level = in_pin & in_drv | in_keep_ff & ~in_drv;
	assign io_level = io_out & io_oe | io_in & io_drv & ~io_oe | io_keep_ff & ~io_drv & ~io_oe;

	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
			in_keep_ff <= '0;
		else
			in_keep_ff <= in_level;
	end

	// The I/O keeper doubles as the pin feedback of a combinatorial macrocell.
	// Taking it from a flop costs one system clock of feedback delay but keeps
	// a macrocell that reads its own pin from forming a combinational loop.
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
			io_keep_ff <= '0;
		else
			io_keep_ff <= io_level;
	end

	for (genvar m = 0; m < MC_N; m++)
	begin : g_mode
		assign mode_reg[m] = fuse_ff[ROW_MODE_BASE+m][MODE_REG_BIT];
		assign mode_pol[m] = fuse_ff[ROW_MODE_BASE+m][MODE_POL_BIT];
	end

	assign fb = mode_reg & mc_q_ff | ~mode_reg & io_keep_ff;
	assign lines = {fb, in_level};

	for (genvar m = 0; m < MC_N; m++)
	begin : g_mc
		for (genvar t = 0; t < TERM_MAX; t++)
		begin : g_pt
			if (t < TERM_CNT[m])
			begin : g_use
				pma_term #(.N_IN(LINES_N)) u_term
				(
					.lines(lines),
					.fuse(fuse_ff[m*TERM_MAX+t]),
					.hit(term_hit[m][t])
				);
			end
			else
			begin : g_off
				assign term_hit[m][t] = 1'h0;
			end
		end
		pma_term #(.N_IN(LINES_N)) u_oe
		(
			.lines(lines),
			.fuse(fuse_ff[ROW_OE_BASE+m]),
			.hit(oe_hit[m])
		);
		assign sum[m] = |term_hit[m];
	end

	pma_term #(.N_IN(LINES_N)) u_ar
	(
		.lines(lines),
		.fuse(fuse_ff[ROW_AR]),
		.hit(ar_hit)
	);

	pma_term #(.N_IN(LINES_N)) u_sp
	(
		.lines(lines),
		.fuse(fuse_ff[ROW_SP]),
		.hit(sp_hit)
	);

	// The reset term masks registered outputs at once, before the flops clear.
	assign q_eff = mc_q_ff & ~{MC_N{ar_hit}};
	assign io_out = mode_pol ^ (mode_reg & q_eff | ~mode_reg & sum);
	assign io_oe = oe_hit;

	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
			clk_pin_q_ff <= 1'h0;
		else
			clk_pin_q_ff <= in_level[CLK_PIN_BIT];
	end

	assign dev_edge = in_level[CLK_PIN_BIT] & ~clk_pin_q_ff;

	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			pu_state_ff <= PU_HOLD;
			pu_cnt_ff <= '0;
		end
		else
		begin
			case (pu_state_ff)
				PU_HOLD:
				begin
					if (pu_cnt_ff == PU_CNT_W'(PU_CYCLES - 1))
						pu_state_ff <= PU_RUN;
					pu_cnt_ff <= pu_cnt_ff + PU_CNT_W'(1);
				end
				PU_RUN:
					pu_cnt_ff <= pu_cnt_ff;
				default:
					pu_state_ff <= PU_HOLD;
			endcase
		end
	end
	assign pu_busy = (pu_state_ff == PU_HOLD);

	// A lock requested in this very cycle already refuses a request beside it.
	assign locked_now = sec_ff | sec_set;
	assign pl_go = pl_we & ~locked_now & ~pu_busy & ~ar_hit;

	// Priority: power-up clear, reset term, preload, then the device clock edge.
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
			mc_q_ff <= '0;
		else if (pu_busy)
			mc_q_ff <= '0;
		else if (ar_hit)
			mc_q_ff <= '0;
		else if (pl_go)
			mc_q_ff <= mc_q_ff & ~pl_mask | pl_data & pl_mask;
		else if (dev_edge && sp_hit)
			mc_q_ff <= '1;
		else if (dev_edge)
			mc_q_ff <= sum;
	end

	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
			for (int r = 0; r < ROW_COUNT; r++)
				fuse_ff[r] <= '0;
		else if (cfg_we && cfg_row < ROW_LIMIT)
			fuse_ff[cfg_row] <= cfg_wdata;
	end

	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
			sec_ff <= 1'h0;
		else if (sec_set)
			sec_ff <= 1'h1;
	end
	assign sec_locked = sec_ff;

	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			rb_data_ff <= '0;
			rb_valid_ff <= 1'h0;
			rb_refused_ff <= 1'h0;
		end
		else
		begin
			rb_valid_ff <= rb_re & ~locked_now;
			rb_refused_ff <= rb_re & locked_now;
			if (rb_re && !locked_now && rb_row < ROW_LIMIT)
				rb_data_ff <= fuse_ff[rb_row];
			else
				rb_data_ff <= '0;
		end
	end
	assign rb_data = rb_data_ff;
	assign rb_valid = rb_valid_ff;
	assign rb_refused = rb_refused_ff;

	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
			pl_refused_ff <= 1'h0;
		else
			pl_refused_ff <= pl_we & locked_now;
	end
	assign pl_refused = pl_refused_ff;

	// The signature ignores the lock on purpose so a secured part stays traceable.
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
			for (int b = 0; b < SIG_BYTES; b++)
				sig_ff[b] <= '0;
		else if (sig_we)
			sig_ff[sig_idx] <= sig_wdata;
	end

	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			sig_data_ff <= '0;
			sig_valid_ff <= 1'h0;
		end
		else
		begin
			sig_valid_ff <= sig_re;
			if (sig_re)
				sig_data_ff <= sig_ff[sig_idx];
		end
	end
	assign sig_data = sig_data_ff;
	assign sig_valid = sig_valid_ff;

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (rst);

	sequence s_pl_req;
		pl_we && !sec_ff && !sec_set && !pu_busy && !ar_hit;
	endsequence
	sequence s_pl_done;
		(mc_q_ff & $past(pl_mask)) == ($past(pl_data) & $past(pl_mask));
	endsequence
	sequence s_pu_last;
		pu_busy && pu_cnt_ff == PU_CNT_W'(PU_CYCLES - 1);
	endsequence

	a_por_clear: assert property (pu_busy |=> mc_q_ff == '0)
		else $error("registers not clear during power-up hold");
	a_por_ends: assert property (s_pu_last |=> !pu_busy ##1 !pu_busy)
		else $error("power-up hold did not end on time");
	a_por_bound: assert property (pu_busy |-> pu_cnt_ff < PU_CNT_W'(PU_CYCLES))
		else $error("power-up hold ran too long");
	a_async_clear: assert property (!pu_busy && ar_hit |=> mc_q_ff == '0)
		else $error("reset term did not clear registers");
	a_sync_preset: assert property (!pu_busy && !ar_hit && !pl_go && dev_edge && sp_hit
		|=> mc_q_ff == '1)
		else $error("preset term did not set registers");
	a_reg_capture: assert property (!pu_busy && !ar_hit && !pl_go && dev_edge && !sp_hit
		|=> mc_q_ff == $past(sum))
		else $error("register missed its sum on clock edge");
	a_preload_force: assert property (s_pl_req |=> s_pl_done)
		else $error("preload did not force masked registers");
	a_preload_lock: assert property (pl_we && (sec_ff || sec_set) |=> pl_refused
		&& ($stable(mc_q_ff) || $past(dev_edge) || $past(ar_hit)))
		else $error("preload not refused while secured");
	a_read_lock: assert property (rb_re && sec_ff |=> rb_refused && !rb_valid && rb_data == '0)
		else $error("readback not refused while secured");
	a_sig_open: assert property (sig_re && !sig_we && sec_ff |=> sig_valid
		&& sig_data == sig_ff[$past(sig_idx)])
		else $error("signature read blocked or wrong");
	a_keeper_hold: assert property (((in_keep_ff ^ $past(in_keep_ff)) & ~$past(in_drv)) == '0)
		else $error("input keeper changed while undriven");
	a_comb_follow: assert property (!mode_reg[0] && !mode_pol[0] |-> io_out[0] == |term_hit[0])
		else $error("combinatorial output not following its sum");
endmodule
